// ---- hw/seq_pkg.sv ----
package seq_pkg;
  // ----------------------------------------------------------------
  // widths and counts
  // ----------------------------------------------------------------
  localparam int CNT_W = 12;
  localparam int HDR_EVT_W = 8;
  localparam int PAY_W = 20;
  localparam int WORD_W = 21;
  localparam int NCHIP = 8;
  localparam int NCHAN = 4;
  localparam int NDATA = 32;
  localparam int NCOL_WORDS = 33;
  localparam int FIFO_DEPTH = 16;
  localparam int DR_DEPTH = 16;
  localparam int L0_LATENCY = 160;
  localparam int LB_DEPTH = 256;
  localparam int TEST_LEN = 256;
  localparam int LANES = 3;
  localparam int BEATS = 7;
  localparam int SAMP_W = 12;
  localparam int TRIG_W = 8;
  // ----------------------------------------------------------------
  // broadcast command bits and reset values
  // ----------------------------------------------------------------
  localparam int CMD_W = 8;
  localparam int CMD_BCR = 0;
  localparam int CMD_L0_RST = 1;
  localparam int CMD_L1_RST = 2;
  localparam int CMD_TEST = 3;
  localparam logic [CNT_W-1:0] BCR_PRESET = 12'h000;
  localparam logic [CNT_W-1:0] EVT_RESET = 12'h000;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_HDR = 3'b001,
    ST_DATA = 3'b011,
    ST_TRL = 3'b010,
    ST_SEP = 3'b110
  } frame_st_t;

  // odd parity on top: the word can never be all zeros
  function automatic logic [WORD_W-1:0] par_enc(logic [PAY_W-1:0] p);
    return {~^p, p};
  endfunction : par_enc
endpackage : seq_pkg

// ---- hw/seq_link_if.sv ----
interface seq_link_if (
  input wire logic clk,
  input wire logic lclk
);
  // serial link, lclk is also the forwarded clock
  logic [seq_pkg::LANES-1:0] ser_data;
  logic ser_frame;
  // front-end control, clk domain
  logic fe_l0_trig;
  logic fe_read;
  logic fe_lb_reset;
  logic fe_test_pulse;
  logic [1:0] fe_ch_sel;
  logic [seq_pkg::NCHIP-1:0][seq_pkg::PAY_W-1:0] fe_data;

  modport seq (
    input clk, lclk, fe_data,
    output ser_data, ser_frame, fe_l0_trig, fe_read, fe_lb_reset,
    output fe_test_pulse, fe_ch_sel
  );
  modport far (
    input clk, lclk, ser_data, ser_frame, fe_l0_trig, fe_read,
    input fe_lb_reset, fe_test_pulse, fe_ch_sel,
    output fe_data
  );
endinterface : seq_link_if

// ---- hw/tmr_counter.sv ----
module tmr_counter #(
  parameter int W = 12
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // control
  input wire logic load,
  input wire logic inc,
  input wire logic [W-1:0] load_val,
  // voted count
  output logic [W-1:0] value
);
  logic [W-1:0] cnt_q [3];
  logic [W-1:0] cnt_d;

  // each copy reloads from the vote, so an upset is scrubbed next edge
  assign value = (cnt_q[0] & cnt_q[1]) | (cnt_q[0] & cnt_q[2]) |
                 (cnt_q[1] & cnt_q[2]);
  assign cnt_d = load ? load_val : (inc ? value + 1'b1 : value);

  for (genvar i = 0; i < 3; i++) begin : g_copy
    always_ff @(posedge clk) begin
      if (!nrst) begin
        cnt_q[i] <= '0;
      end else begin
        cnt_q[i] <= cnt_d;
      end
    end
  end
endmodule : tmr_counter

// ---- hw/seq_sequencer.sv ----
module seq_sequencer #(
  parameter int FIFO_DEPTH_P = seq_pkg::FIFO_DEPTH,
  parameter logic [seq_pkg::CNT_W-1:0] BCR_PRESET_P = seq_pkg::BCR_PRESET
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // link and front-end chips
  seq_link_if.seq lnk,
  // trigger and broadcast
  input wire logic level0_accept,
  input wire logic bcast_strobe,
  input wire logic [seq_pkg::CMD_W-1:0] bcast_cmd,
  // status
  output logic l1_fe_reset,
  output logic [seq_pkg::CNT_W-1:0] crossing_number,
  output logic [seq_pkg::CNT_W-1:0] event_number,
  output logic fifo_full
);
  import seq_pkg::*;

  localparam int FAW = $clog2(FIFO_DEPTH_P);
  localparam int KW = $clog2(NDATA);
  localparam int BW = $clog2(BEATS);
  localparam int EW = 2 * CNT_W;

  // ----------------------------------------------------------------
  // broadcast decode and counters
  // ----------------------------------------------------------------
  logic cmd_bcr;
  logic cmd_l0rst;
  logic cmd_l1rst;
  logic cmd_test;
  logic push;
  logic l1rst_q;
  logic lbrst_q;
  logic test_q;
  logic trig_q;

  assign cmd_bcr = bcast_strobe & bcast_cmd[CMD_BCR];
  assign cmd_l0rst = bcast_strobe & bcast_cmd[CMD_L0_RST];
  assign cmd_l1rst = bcast_strobe & bcast_cmd[CMD_L1_RST];
  assign cmd_test = bcast_strobe & bcast_cmd[CMD_TEST];

  // crossing counter preset on crossing reset
  tmr_counter #(.W(CNT_W)) u_crossing (
    .clk(clk),
    .nrst(nrst),
    .load(cmd_bcr),
    .inc(1'b1),
    .load_val(BCR_PRESET_P),
    .value(crossing_number)
  );

  // event counter moves on the same edge the entry is written
  tmr_counter #(.W(CNT_W)) u_event (
    .clk(clk),
    .nrst(nrst),
    .load(cmd_l0rst),
    .inc(push),
    .load_val(EVT_RESET),
    .value(event_number)
  );

  always_ff @(posedge clk) begin
    if (!nrst) begin
      l1rst_q <= 1'b0;
      lbrst_q <= 1'b0;
      test_q <= 1'b0;
      trig_q <= 1'b0;
    end else begin
      l1rst_q <= cmd_l1rst;
      lbrst_q <= cmd_l0rst;
      test_q <= cmd_test;
      trig_q <= level0_accept;
    end
  end

  assign l1_fe_reset = l1rst_q;
  assign lnk.fe_lb_reset = lbrst_q;
  assign lnk.fe_test_pulse = test_q;
  assign lnk.fe_l0_trig = trig_q;

  // ----------------------------------------------------------------
  // level-0 derandomiser
  // ----------------------------------------------------------------
  logic [EW-1:0] fifo_q [FIFO_DEPTH_P];
  logic [FAW:0] wr_q;
  logic [FAW:0] rd_q;
  logic empty;
  logic pop;

  assign empty = (wr_q == rd_q);
  assign fifo_full = (wr_q[FAW] != rd_q[FAW]) &&
                     (wr_q[FAW-1:0] == rd_q[FAW-1:0]);
  // an accept into a full fifo is lost; depth matches the chips
  assign push = level0_accept & ~fifo_full;

  always_ff @(posedge clk) begin
    if (push) begin
      fifo_q[wr_q[FAW-1:0]] <= {event_number, crossing_number};
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_q + (FAW+1)'(push);
      rd_q <= rd_q + (FAW+1)'(pop);
    end
  end

  // ----------------------------------------------------------------
  // event framer
  // ----------------------------------------------------------------
  frame_st_t st_q;
  frame_st_t st_d;
  logic [EW-1:0] evt_q;
  logic [KW-1:0] k_q;
  logic [PAY_W-1:0] col_q;
  logic [PAY_W-1:0] col_d;
  logic [PAY_W-1:0] hdr_pay;
  logic [PAY_W-1:0] dat_pay;
  logic [WORD_W-1:0] word_q [2];
  logic [WORD_W-1:0] word_d;
  logic [1:0] wtog_q;
  logic wsel_q;
  logic busy;
  logic send;
  logic read_q;
  logic [2:0][1:0] ack_s_q;
  logic [1:0] ltaken_q;

  // two word slots: one handshake round trip outlasts a word time,
  // so the next word is handed over while the last one is on the wire
  assign busy = (wtog_q[wsel_q] != ack_s_q[2][wsel_q]);
  assign hdr_pay = {evt_q[EW-CNT_W +: HDR_EVT_W], evt_q[CNT_W-1:0]};
  assign dat_pay = lnk.fe_data[k_q[KW-1:2]];
  assign lnk.fe_ch_sel = k_q[1:0];
  assign lnk.fe_read = read_q;
  assign pop = (st_q == ST_IDLE) & ~empty;

  always_comb begin
    st_d = st_q;
    word_d = '0;
    send = 1'b0;
    col_d = col_q;
    case (st_q)
      ST_IDLE: begin
        if (!empty) begin
          st_d = ST_HDR;
        end
      end
      ST_HDR: begin
        if (!busy) begin
          word_d = par_enc(hdr_pay);
          col_d = hdr_pay;
          send = 1'b1;
          st_d = ST_DATA;
        end
      end
      ST_DATA: begin
        if (!busy) begin
          word_d = par_enc(dat_pay);
          col_d = col_q ^ dat_pay;
          send = 1'b1;
          if (k_q == KW'(NDATA - 1)) begin
            st_d = ST_TRL;
          end
        end
      end
      ST_TRL: begin
        if (!busy) begin
          word_d = par_enc(~col_q);
          send = 1'b1;
          st_d = ST_SEP;
        end
      end
      ST_SEP: begin
        if (!busy) begin
          word_d = '0;
          send = 1'b1;
          st_d = ST_IDLE;
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_q <= ST_IDLE;
      evt_q <= '0;
      k_q <= '0;
      col_q <= '0;
      word_q[0] <= '0;
      word_q[1] <= '0;
      wtog_q <= '0;
      wsel_q <= 1'b0;
      read_q <= 1'b0;
    end else begin
      st_q <= st_d;
      col_q <= col_d;
      read_q <= pop;
      if (pop) begin
        evt_q <= fifo_q[rd_q[FAW-1:0]];
      end
      if (st_q == ST_HDR) begin
        k_q <= '0;
      end else if (st_q == ST_DATA && send) begin
        k_q <= k_q + 1'b1;
      end
      if (send) begin
        word_q[wsel_q] <= word_d;
        wtog_q[wsel_q] <= ~wtog_q[wsel_q];
        wsel_q <= ~wsel_q;
      end
    end
  end

  // taken-word toggle back from the link side
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ack_s_q <= '0;
    end else begin
      ack_s_q <= {ack_s_q[1:0], ltaken_q};
    end
  end

  // ----------------------------------------------------------------
  // serializer, link clock domain
  // ----------------------------------------------------------------
  logic [2:0] lrst_s_q;
  logic [2:0][1:0] wtog_s_q;
  logic rsel_q;
  logic lnext;
  logic [BW-1:0] beat_q;
  logic [WORD_W-1:0] sh_q;
  logic lnrst;

  assign lnrst = lrst_s_q[2];
  assign lnext = (wtog_s_q[2][rsel_q] != ltaken_q[rsel_q]);

  always_ff @(posedge lnk.lclk) begin
    lrst_s_q <= {lrst_s_q[1:0], nrst};
  end

  // a slot is held still until its toggle comes back, so it is safe
  // to sample here once the third stage has seen the change
  always_ff @(posedge lnk.lclk) begin
    if (!lnrst) begin
      wtog_s_q <= '0;
      ltaken_q <= '0;
      rsel_q <= 1'b0;
      beat_q <= '0;
      sh_q <= '0;
    end else begin
      wtog_s_q <= {wtog_s_q[1:0], wtog_q};
      if (beat_q == BW'(BEATS - 1)) begin
        beat_q <= '0;
        if (lnext) begin
          sh_q <= word_q[rsel_q];
          ltaken_q[rsel_q] <= wtog_s_q[2][rsel_q];
          rsel_q <= ~rsel_q;
        end else begin
          sh_q <= '0;
        end
      end else begin
        beat_q <= beat_q + 1'b1;
        sh_q <= sh_q >> LANES;
      end
    end
  end

  assign lnk.ser_data = sh_q[LANES-1:0];
  assign lnk.ser_frame = (beat_q == '0);
endmodule : seq_sequencer

// ---- hw/seq_far_end.sv ----
module seq_far_end (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // link and front-end pins
  seq_link_if.far lnk,
  // front-end inputs and test address output
  input wire logic [seq_pkg::NCHIP*seq_pkg::NCHAN-1:0][11:0] sample,
  input wire logic [seq_pkg::NCHIP*seq_pkg::NCHAN-1:0][7:0] trig_val,
  input wire logic [seq_pkg::NCHIP*seq_pkg::NCHAN-1:0] pattern_mode,
  input wire logic [seq_pkg::NCHIP*seq_pkg::NCHAN-1:0][11:0] pat_sample,
  output logic [7:0] test_addr,
  // received words
  output logic [seq_pkg::WORD_W-1:0] rx_word,
  output logic rx_valid,
  output logic rx_header
);
  import seq_pkg::*;

  localparam int LAW = $clog2(LB_DEPTH);
  localparam int DAW = $clog2(DR_DEPTH);
  localparam int BW = $clog2(BEATS);

  // ----------------------------------------------------------------
  // test sequence, one counter for all chips
  // ----------------------------------------------------------------
  logic [LAW-1:0] tcnt_q;
  logic trun_q;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      tcnt_q <= '0;
      trun_q <= 1'b0;
    end else if (lnk.fe_test_pulse) begin
      tcnt_q <= '0;
      trun_q <= 1'b1;
    end else if (trun_q) begin
      tcnt_q <= tcnt_q + 1'b1;
      trun_q <= (tcnt_q != LAW'(TEST_LEN - 1));
    end
  end
  assign test_addr = tcnt_q;

  // ----------------------------------------------------------------
  // front-end chips
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NCHIP; g++) begin : g_chip
    logic [NCHAN-1:0][PAY_W-1:0] lb_q [LB_DEPTH];
    logic [NCHAN-1:0][PAY_W-1:0] dr_q [DR_DEPTH];
    logic [NCHAN-1:0][PAY_W-1:0] in_w;
    logic [NCHAN-1:0][PAY_W-1:0] out_q;
    logic [NCHAN-1:0][SAMP_W-1:0] dly_q;
    logic [LAW-1:0] wp_q;
    logic [DAW:0] dw_q;
    logic [DAW:0] dr_rd_q;
    logic dpush;
    logic dpop;

    for (genvar c = 0; c < NCHAN; c++) begin : g_ch
      localparam int N = g * NCHAN + c;
      always_ff @(posedge clk) begin
        dly_q[c] <= pattern_mode[N] ? pat_sample[N] : sample[N];
      end
      assign in_w[c] = {trig_val[N], dly_q[c]};
    end

    assign dpush = lnk.fe_l0_trig &&
                   !((dw_q[DAW] != dr_rd_q[DAW]) &&
                     (dw_q[DAW-1:0] == dr_rd_q[DAW-1:0]));
    assign dpop = lnk.fe_read && (dw_q != dr_rd_q);

    always_ff @(posedge clk) begin
      lb_q[wp_q] <= in_w;
      if (dpush) begin
        dr_q[dw_q[DAW-1:0]] <= lb_q[wp_q - LAW'(L0_LATENCY)];
      end
    end

    always_ff @(posedge clk) begin
      if (!nrst || lnk.fe_lb_reset) begin
        wp_q <= '0;
      end else begin
        wp_q <= wp_q + 1'b1;
      end
    end

    always_ff @(posedge clk) begin
      if (!nrst) begin
        dw_q <= '0;
        dr_rd_q <= '0;
        out_q <= '0;
      end else begin
        dw_q <= dw_q + (DAW+1)'(dpush);
        dr_rd_q <= dr_rd_q + (DAW+1)'(dpop);
        if (dpop) begin
          out_q <= dr_q[dr_rd_q[DAW-1:0]];
        end
      end
    end

    assign lnk.fe_data[g] = out_q[lnk.fe_ch_sel];
  end

  // ----------------------------------------------------------------
  // deserializer, link clock domain
  // ----------------------------------------------------------------
  logic [2:0] lrst_s_q;
  logic [WORD_W-1:0] sh_q;
  logic [WORD_W-1:0] sh_d;
  logic [WORD_W-1:0] hold_q;
  logic [BW-1:0] bcnt_q;
  logic rtog_q;

  assign sh_d = {lnk.ser_data, sh_q[WORD_W-1:LANES]};

  always_ff @(posedge lnk.lclk) begin
    lrst_s_q <= {lrst_s_q[1:0], nrst};
  end

  always_ff @(posedge lnk.lclk) begin
    if (!lrst_s_q[2]) begin
      sh_q <= '0;
      hold_q <= '0;
      bcnt_q <= '0;
      rtog_q <= 1'b0;
    end else begin
      sh_q <= sh_d;
      if (bcnt_q == BW'(BEATS - 1)) begin
        hold_q <= sh_d;
        rtog_q <= ~rtog_q;
        bcnt_q <= '0;
      end else if (lnk.ser_frame) begin
        bcnt_q <= BW'(1);
      end else if (bcnt_q != '0) begin
        bcnt_q <= bcnt_q + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // header detection, clk domain
  // ----------------------------------------------------------------
  logic [2:0] rtog_s_q;
  logic rseen_q;
  logic rnew;
  logic zprev_q;
  logic [5:0] blk_q;
  logic hit;

  assign rnew = (rtog_s_q[2] != rseen_q);
  // hold_q is stable a full word time, longer than the sync delay
  assign hit = rnew && (blk_q == '0) && zprev_q &&
               (hold_q != '0);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rtog_s_q <= '0;
      rseen_q <= 1'b0;
      zprev_q <= 1'b0;
      blk_q <= '0;
      rx_word <= '0;
      rx_valid <= 1'b0;
      rx_header <= 1'b0;
    end else begin
      rtog_s_q <= {rtog_s_q[1:0], rtog_q};
      rseen_q <= rtog_s_q[2];
      rx_valid <= rnew;
      rx_header <= hit;
      if (rnew) begin
        rx_word <= hold_q;
        zprev_q <= (hold_q == '0);
        if (hit) begin
          blk_q <= 6'(NCOL_WORDS);
        end else if (blk_q != '0) begin
          blk_q <= blk_q - 1'b1;
        end
      end
    end
  end
endmodule : seq_far_end

// ---- verification/seq_link_chk.sv ----
module seq_link_chk (
  // clocks and reset
  input wire logic clk,
  input wire logic lclk,
  input wire logic nrst,
  // watched link signals
  input wire logic [seq_pkg::LANES-1:0] ser_data,
  input wire logic ser_frame,
  input wire logic fe_l0_trig,
  input wire logic fe_read
);
  import seq_pkg::*;
  // ----------------------------------------------------------------
  // word rebuild on the lclk side
  // ----------------------------------------------------------------
  logic [WORD_W-1:0] sh_q;
  logic [5:0] idx_q;
  logic [PAY_W-1:0] col_q;
  logic zero_q;
  logic seen_q;
  logic [7:0] gap_q;
  logic [7:0] pend_q;
  wire hdr = zero_q && (sh_q != '0) && (idx_q == 6'h00);
  wire idx_end = (idx_q == 6'h00) || (idx_q == 6'h22);
  wire [5:0] idx_d = hdr ? 6'h01 : idx_end ? 6'h00 : idx_q + 6'h01;
  // cleared on reset so a half word cut by reset is never judged
  always_ff @(posedge lclk) begin
    if (!nrst) begin
      sh_q <= '0;
      idx_q <= '0;
      col_q <= '0;
      zero_q <= 1'b0;
    end else begin
      sh_q <= {ser_data, sh_q[WORD_W-1:LANES]};
      if (ser_frame) begin
        zero_q <= (sh_q == '0);
        col_q <= hdr ? sh_q[PAY_W-1:0] : col_q ^ sh_q[PAY_W-1:0];
        idx_q <= idx_d;
      end
    end
  end
  // ----------------------------------------------------------------
  // read pacing on the clk side
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      seen_q <= 1'b0;
      gap_q <= 8'hff;
      pend_q <= 8'h00;
    end else begin
      seen_q <= seen_q | fe_read;
      gap_q <= fe_read ? 8'h00 : (gap_q == 8'hff) ? gap_q : gap_q + 8'h01;
      pend_q <= pend_q + {7'h00, fe_l0_trig} - {7'h00, fe_read};
    end
  end
  chk_frame_period: assert property (
    @(posedge lclk) disable iff (!nrst)
    $fell(ser_frame) |-> !ser_frame [*6] ##1 ser_frame)
    else $error("frame marker period wrong");
  chk_word_parity: assert property (
    @(posedge lclk) disable iff (!nrst)
    ser_frame |-> (sh_q == '0) || (^sh_q))
    else $error("link word parity even");
  chk_body_nonzero: assert property (
    @(posedge lclk) disable iff (!nrst)
    ser_frame && idx_q inside {[1:33]} |-> sh_q != '0)
    else $error("zero word inside event");
  chk_sep_zero: assert property (
    @(posedge lclk) disable iff (!nrst)
    ser_frame && idx_q == 6'h22 |-> sh_q == '0)
    else $error("separator word not zero");
  chk_trailer_cols: assert property (
    @(posedge lclk) disable iff (!nrst)
    ser_frame && idx_q == 6'h21 |-> sh_q[PAY_W-1:0] == ~col_q)
    else $error("trailer column parity wrong");
  chk_idle_zero: assert property (
    @(posedge lclk) disable iff (!nrst)
    ser_frame && !seen_q |-> sh_q == '0)
    else $error("nonzero word while idle");
  chk_read_gap: assert property (
    @(posedge clk) disable iff (!nrst)
    fe_read |-> gap_q >= 8'd150)
    else $error("read before event framed");
  chk_read_pend: assert property (
    @(posedge clk) disable iff (!nrst)
    fe_read |-> pend_q != 8'h00)
    else $error("read without trigger");
endmodule : seq_link_chk

// ---- verification/tb.sv ----
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import seq_pkg::*;
  // ----------------------------------------------------------------
  // rows: command, pulses {test, l1, lb}, pattern mode, inputs
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] cmd;
    logic [2:0] pul;
    logic pm;
    logic [11:0] smp;
    logic [7:0] trg;
  } row_t;
  localparam logic [11:0] PRE = 12'h5a3;
  localparam row_t ROWS [6] = '{
    '{8'h00, 3'h0, 1'b0, 12'h123, 8'h45},
    '{8'h01, 3'h0, 1'b0, 12'hfff, 8'h00},
    '{8'h02, 3'h1, 1'b0, 12'h000, 8'hff},
    '{8'h04, 3'h2, 1'b0, 12'h8a5, 8'h3c},
    '{8'h08, 3'h4, 1'b1, 12'h0f0, 8'h81},
    '{8'h0e, 3'h7, 1'b0, 12'h777, 8'h10}
  };
  logic clk = 0;
  logic lclk = 0;
  logic nrst = 0;
  logic acc = 0;
  logic stb = 0;
  logic [7:0] cmd = '0;
  logic [31:0][11:0] smp, psmp;
  logic [31:0][7:0] trg;
  logic [31:0] pm;
  logic l1r, full, rxv, rxh;
  logic [11:0] xn_o, en_o, xn, en;
  logic [7:0] taddr, ta;
  logic [20:0] rxw;
  logic [19:0] col;
  logic [20:0] hq [$];
  int fails = 0;
  int compares = 0;
  int sent = 0;
  int got = 0;
  int idx = -1;
  initial forever #4 clk = ~clk;
  initial begin
    #1.3;
    forever #3 lclk = ~lclk;
  end
  seq_link_if lnk (.clk(clk), .lclk(lclk));
  seq_sequencer #(.BCR_PRESET_P(PRE)) i_seq_sequencer (
    .clk(clk),
    .nrst(nrst),
    .lnk(lnk),
    .level0_accept(acc),
    .bcast_strobe(stb),
    .bcast_cmd(cmd),
    .l1_fe_reset(l1r),
    .crossing_number(xn_o),
    .event_number(en_o),
    .fifo_full(full)
  );
  seq_far_end i_seq_far_end (
    .clk(clk),
    .nrst(nrst),
    .lnk(lnk),
    .sample(smp),
    .trig_val(trg),
    .pattern_mode(pm),
    .pat_sample(psmp),
    .test_addr(taddr),
    .rx_word(rxw),
    .rx_valid(rxv),
    .rx_header(rxh)
  );
  seq_link_chk i_seq_link_chk (
    .clk(clk),
    .lclk(lclk),
    .nrst(nrst),
    .ser_data(lnk.ser_data),
    .ser_frame(lnk.ser_frame),
    .fe_l0_trig(lnk.fe_l0_trig),
    .fe_read(lnk.fe_read)
  );
  wire [2:0] pul = {lnk.fe_test_pulse, l1r, lnk.fe_lb_reset};
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [20:0] enc(logic [19:0] p);
    return {~^p, p};
  endfunction : enc
  function automatic logic [19:0] pay(int k);
    return {trg[k], pm[k] ? psmp[k] : smp[k]};
  endfunction : pay
  task automatic stop_test();
    if (fails == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  task automatic cmp_w(input logic [20:0] a, input logic [20:0] e);
    compares++;
    if (a !== e) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, a, e);
    end
  endtask : cmp_w
  task automatic cmp_n(input logic [11:0] a, input logic [11:0] e);
    compares++;
    if (a !== e) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, a, e);
    end
  endtask : cmp_n
  task automatic setin(input row_t r);
    for (int k = 0; k < 32; k++) begin
      smp[k] = r.smp ^ 12'(k);
      psmp[k] = ~smp[k];
      trg[k] = r.trg + 8'(k);
    end
    pm = {32{r.pm}};
  endtask : setin
  task automatic bcmd(input logic [7:0] c, input logic [2:0] p);
    @(negedge clk);
    stb = 1;
    cmd = c;
    @(negedge clk);
    stb = 0;
    cmd = '0;
    cmp_n({9'h0, pul}, {9'h0, p});
  endtask : bcmd
  task automatic accept(input int n);
    @(negedge clk);
    acc = 1;
    repeat (n) @(negedge clk);
    acc = 0;
  endtask : accept
  task automatic drain();
    for (int i = 0; i < 5000 && got != sent; i++) @(negedge clk);
    cmp_n(12'(got), 12'(sent));
  endtask : drain
  // ----------------------------------------------------------------
  // counter model and receive monitor
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (!nrst) begin
      xn = '0;
      en = '0;
      hq.delete();
      idx = -1;
      sent = got;
    end else begin
      if (acc && !full) begin
        hq.push_back(enc({en[7:0], xn}));
        en = en + 12'h1;
        sent++;
      end
      xn = (stb && cmd[0]) ? PRE : xn + 12'h1;
      if (stb && cmd[1])
        en = '0;
      if (rxv && rxh) begin
        cmp_w(rxw, hq.size() ? hq.pop_front() : 21'h0);
        col = rxw[19:0];
        idx = 0;
      end else if (rxv && idx >= 0 && idx < 32) begin
        cmp_w(rxw, enc(pay(idx)));
        col = col ^ pay(idx);
        idx++;
      end else if (rxv && idx == 32) begin
        cmp_w(rxw, enc(~col));
        idx = -1;
        got++;
      end
    end
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    setin(ROWS[0]);
    repeat (8) @(negedge clk);
    nrst = 1;
    foreach (ROWS[i]) begin
      setin(ROWS[i]);
      bcmd(ROWS[i].cmd, ROWS[i].pul);
      if (ROWS[i].cmd[3]) begin
        repeat (3) @(negedge clk);
        ta = taddr;
        repeat (100) @(negedge clk);
        cmp_n({4'h0, taddr - ta}, 12'd100);
      end
      // latency buffer fully rewritten with the new inputs first
      repeat (260) @(negedge clk);
      accept(1);
      drain();
      cmp_n(xn_o, xn);
      cmp_n(en_o, en);
    end
    accept(3);
    drain();
    @(negedge clk);
    acc = 1;
    for (int i = 0; i < 20; i++) begin
      // the first entry leaves at once, so sixteen more fill it
      cmp_n({11'h0, full}, {11'h0, i >= 17});
      @(negedge clk);
    end
    acc = 0;
    drain();
    accept(1);
    repeat (40) @(negedge clk);
    nrst = 0;
    repeat (8) @(negedge clk);
    cmp_n(xn_o, 12'h0);
    cmp_n(en_o, 12'h0);
    cmp_n({11'h0, full}, 12'h0);
    nrst = 1;
    repeat (260) @(negedge clk);
    accept(1);
    drain();
    cmp_n(xn_o, xn);
    stop_test();
  end
  initial begin
    #200us;
    fails++;
    stop_test();
  end
endmodule : tb
